// ==== verilog/sop_serial_out.sv ====
// Serial output port of a dual simultaneous-sampling converter.
// Assumes results arrive on the core clock; all pins are asynchronous.
//
// Contract
// - Serial mode: shared pin inverts serial clock.
// - Parallel mode: shared pins carry bits 6-8.
// - Chain/read-mode pin meaning follows clock source.
// - Slave: chain input appears 32 clocks later.
// - Master, read-mode high: previous data during conversion.
// - Master, read-mode low: shift after conversion only.
// - Serial mode: data pin is serial output.
// - Both results held in 32-bit shift register.
// - Each result leaves MSB first.
// - Channel order select picks first channel.
// - Order high: A then B; low: B then A.
// - Master: data valid on both clock edges.
// - Slave, no inversion: update on rising edge.
// - Slave, inverted: update on falling edge.
// - Source low drives clock; high uses host clock.
// - Select low parallel; high serial on subset.

`timescale 1ns/1ps

module sop_serial_out import sop_pkg::*; #(
   parameter int unsigned CLK_DIV = SCLK_DIV_DEF,
   parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // Mode pins.
   input wire logic serial_parallel_select_in,
   input wire logic clock_source_select_in,
   input wire logic channel_order_select_in,
   input wire logic read_select_n_in,
   // Shared pin carrying bit 6 or the clock invert select.
   input wire logic clock_invert_select_in,
   output logic parallel_bit6_out,
   output logic parallel_bit6_oe_out,
   // Shared pin carrying bit 7 or the read mode / chain input.
   input wire logic read_mode_or_chain_input_in,
   output logic parallel_bit7_out,
   output logic parallel_bit7_oe_out,
   // Shared pin carrying bit 8 or the serial data.
   output logic serial_result_out,
   // Serial clock pin.
   input wire logic serial_clk_in,
   output logic serial_clk_out,
   output logic serial_clk_oe_out,
   // Converter side.
   input wire logic [CHAN_W-1:0] result_a_in,
   input wire logic [CHAN_W-1:0] result_b_in,
   input wire logic result_valid_in,
   output logic result_ready_out,
   input wire logic busy_in,
   output logic read_active_out
);

   // ****************************************************************
   // State.
   // ****************************************************************
   typedef struct packed {
      logic [CFG_W-1:0] s1;
      logic [CFG_W-1:0] s2;
      logic ck_prev;
      logic rs_prev;
      logic busy_prev;
      logic [WORD_W-1:0] sr;
      logic [CNT_W-1:0] cnt;
      logic [1:0] phase;
      logic active;
      logic mclk;
      logic sdo;
      logic [2:0] par;
      logic pin6;
      logic pin7;
      logic pin8;
      logic oe_par;
      logic clk_pin;
      logic clk_oe;
   } sop_st_t;

   sop_st_t q, d;

   logic tick;
   logic fifo_valid;
   logic [WORD_W-1:0] fifo_data;
   logic fifo_ready;
   logic pop;
   logic [WORD_W-1:0] ordered;
   logic ser;
   logic ext;
   logic inv;
   logic chain;
   logic sck_eff;
   logic sck_eff_prev;
   logic upd;
   logic slave_start;
   logic master_start;

   // Refuse a divider below one or a FIFO depth below two; the FIFO itself refuses a depth that is not a power of two.
   if (CLK_DIV < 1 || FIFO_DEPTH < 2) begin : g_chk
      $error("Serial clock divider or FIFO depth out of range.");
   end

   // ****************************************************************
   // Helpers: serial clock divider and result FIFO.
   // ****************************************************************
   sop_tick_div #(
      .DIV(CLK_DIV)
   ) u_div (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .tick_out(tick)
   );

   // The channel order is fixed when the result is captured.
   // The select is read after its synchroniser, like every other pin.
   assign ordered = q.s2[CFG_ORD] ? {result_a_in, result_b_in}
                                  : {result_b_in, result_a_in};

   sop_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .in_valid_in(result_valid_in),
      .in_data_in(ordered),
      .in_ready_out(fifo_ready),
      .out_valid_out(fifo_valid),
      .out_data_out(fifo_data),
      .out_ready_in(pop)
   );

   // ****************************************************************
   // Next state.
   // ****************************************************************
   always_comb begin
      d = q;
      d.s1 = {read_select_n_in, serial_clk_in, channel_order_select_in,
              read_mode_or_chain_input_in, clock_invert_select_in,
              clock_source_select_in, serial_parallel_select_in};
      d.s2 = q.s1;
      ser = q.s2[CFG_SER];
      ext = q.s2[CFG_EXT];
      inv = q.s2[CFG_INV];
      chain = q.s2[CFG_RDC];
      d.ck_prev = q.s2[CFG_SCK];
      d.rs_prev = q.s2[CFG_RSN];
      d.busy_prev = busy_in;
      // The host clock is folded with the invert select so one edge updates.
      sck_eff = q.s2[CFG_SCK] ^ inv;
      sck_eff_prev = q.ck_prev ^ inv;
      upd = ser && ext && q.active && sck_eff && !sck_eff_prev;
      slave_start = ser && ext && !q.s2[CFG_RSN] && q.rs_prev;
      // Read mode decides whether the frame overlaps a conversion.
      master_start = ser && !ext && !q.active && fifo_valid &&
                     (chain ? (busy_in && !q.busy_prev)
                            : !busy_in);
      pop = slave_start || master_start;

      // Parallel bits come from the channel that the order select picks.
      if (result_valid_in) begin
         d.par = q.s2[CFG_ORD]
                 ? result_a_in[PAR_BIT8:PAR_BIT6]
                 : result_b_in[PAR_BIT8:PAR_BIT6];
      end

      if (master_start) begin
         d.sr = fifo_data;
         d.sdo = fifo_data[WORD_W-1];
         d.cnt = '0;
         d.phase = PH_RISE;
         d.mclk = 1'b0;
         d.active = 1'b1;
      end else if (ser && !ext && q.active && tick) begin
         d.phase = q.phase + 2'h1;
         if (q.phase == PH_RISE) begin
            d.mclk = 1'b1;
         end else if (q.phase == PH_FALL) begin
            d.mclk = 1'b0;
         end else if (q.phase == PH_UPD) begin
            // Data move midway through the low half, clear of both edges.
            if (q.cnt == FRAME_LAST) begin
               d.active = 1'b0;
            end else begin
               d.cnt = q.cnt + CNT_W'(1);
               d.sr = {q.sr[WORD_W-2:0], 1'b0};
               d.sdo = q.sr[WORD_W-2];
            end
         end
      end else if (slave_start) begin
         if (fifo_valid) begin
            d.sr = fifo_data;
            d.sdo = fifo_data[WORD_W-1];
         end else begin
            d.sdo = q.sr[WORD_W-1];
         end
         d.active = 1'b1;
      end else if (upd) begin
         // Chain bits enter at the bottom and follow the local word out.
         d.sr = {q.sr[WORD_W-2:0], chain};
         d.sdo = q.sr[WORD_W-2];
      end else if (ser && ext && q.active && q.s2[CFG_RSN]) begin
         d.active = 1'b0;
      end

      if (!ser || (!ext && !q.active && !master_start)) begin
         if (!ext || !ser) begin
            d.active = q.active && ser;
         end
      end

      // Pin drivers.
      // Bits six and seven only matter while the parallel port owns the pins.
      d.oe_par = !ser;
      d.pin6 = d.par[0];
      d.pin7 = d.par[1];
      d.pin8 = ser ? d.sdo : d.par[2];
      d.clk_oe = ser && !ext;
      d.clk_pin = d.mclk ^ inv;
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         q <= '0;
         q.rs_prev <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   assign parallel_bit6_out = q.pin6;
   assign parallel_bit6_oe_out = q.oe_par;
   assign parallel_bit7_out = q.pin7;
   assign parallel_bit7_oe_out = q.oe_par;
   assign serial_result_out = q.pin8;
   assign serial_clk_out = q.clk_pin;
   assign serial_clk_oe_out = q.clk_oe;
   assign result_ready_out = fifo_ready;
   assign read_active_out = q.active;

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rstn_in);

   a_par_pins_drive: assert property (!q.s2[CFG_SER] |=> q.oe_par && serial_result_out == q.par[2])
      else $error("Parallel mode does not drive the shared pins.");

   a_ser_pins_free: assert property (q.s2[CFG_SER] |=> !parallel_bit6_oe_out && !parallel_bit7_oe_out)
      else $error("Serial mode still drives the select pins.");

   a_master_clk_own: assert property (q.s2[CFG_SER] && !q.s2[CFG_EXT] |=> serial_clk_oe_out)
      else $error("Master mode does not drive the serial clock.");

   a_slave_clk_free: assert property (q.s2[CFG_SER] && q.s2[CFG_EXT] |=> !serial_clk_oe_out)
      else $error("Slave mode drives the serial clock.");

   a_master_data_mid: assert property (q.active && !q.s2[CFG_EXT] && $past(q.active)
      && $changed(q.sdo) |-> $past(tick) && $past(q.phase) == PH_UPD)
      else $error("Master data changed away from the update phase.");

   a_slave_edge_only: assert property (q.active && q.s2[CFG_EXT] && $past(q.active)
      && $changed(q.sr) |-> $past(upd))
      else $error("Slave shift outside an update edge.");

   a_chain_enters: assert property (upd |=> q.sr[0] == $past(chain))
      else $error("Chain bit not captured at the update edge.");

   a_master_msb_first: assert property (master_start |=> q.sdo == q.sr[WORD_W-1]
      && q.cnt == '0 ##1 q.cnt == '0)
      else $error("Frame did not start with the most significant bit.");

   a_rdc_low_waits: assert property (master_start && !chain |-> !busy_in)
      else $error("Read-after-convert frame began during conversion.");

   // ****************************************************************
   // Frame and pin checks.
   // ****************************************************************
   // Each pin check looks one cycle on, where the registered pin has settled.

   a_par_bits_follow: assert property (!q.s2[CFG_SER]
      |=> parallel_bit6_out == q.par[0] && parallel_bit7_out == q.par[1])
      else $error("Parallel bits six and seven do not follow the result.");

   a_pin_follows_data: assert property (q.s2[CFG_SER] |=> serial_result_out == q.sdo)
      else $error("Serial data pin does not carry the shift register output.");

   a_clk_pin_invert: assert property (q.s2[CFG_SER] && !q.s2[CFG_EXT]
      |=> serial_clk_out == (q.mclk ^ $past(q.s2[CFG_INV])))
      else $error("Serial clock pin ignores the invert select.");

   a_master_frame_len: assert property ($fell(q.active)
      && $past(q.s2[CFG_SER] && !q.s2[CFG_EXT]) |-> $past(q.cnt) == FRAME_LAST)
      else $error("Master frame did not run for all result bits.");

   a_slave_load_word: assert property (slave_start && fifo_valid
      |=> q.sr == $past(fifo_data) && q.sdo == q.sr[WORD_W-1])
      else $error("Host read did not load the next result with its top bit first.");

   a_chain_shift_out: assert property (upd && !slave_start
      |=> q.sdo == $past(q.sr[WORD_W-2]))
      else $error("Update edge did not move the next bit to the data pin.");

endmodule

// ==== verilog/sop_pkg.sv ====
// Constants shared by the serial output port and its helper modules.
// Assumes a single 100 MHz core clock and a 16-bit two-channel converter.

package sop_pkg;

   // ****************************************************************
   // Data widths.
   // ****************************************************************
   localparam int unsigned CHAN_W = 16;
   localparam int unsigned WORD_W = 2 * CHAN_W;
   localparam int unsigned CNT_W = 5;
   localparam logic [CNT_W-1:0] FRAME_LAST = 5'h1f;

   // ****************************************************************
   // Positions of the synchronised pin inputs.
   // ****************************************************************
   localparam int unsigned CFG_SER = 0;
   localparam int unsigned CFG_EXT = 1;
   localparam int unsigned CFG_INV = 2;
   localparam int unsigned CFG_RDC = 3;
   localparam int unsigned CFG_ORD = 4;
   localparam int unsigned CFG_SCK = 5;
   localparam int unsigned CFG_RSN = 6;
   localparam int unsigned CFG_W = 7;

   // ****************************************************************
   // Parallel result bits carried by the shared pins.
   // ****************************************************************
   localparam int unsigned PAR_BIT6 = 6;
   localparam int unsigned PAR_BIT7 = 7;
   localparam int unsigned PAR_BIT8 = 8;

   // ****************************************************************
   // Master clock phases: rise, fall, data update.
   // ****************************************************************
   localparam logic [1:0] PH_RISE = 2'h0;
   localparam logic [1:0] PH_FALL = 2'h2;
   localparam logic [1:0] PH_UPD = 2'h3;

   // ****************************************************************
   // Defaults of the top-level parameters.
   // ****************************************************************
   localparam int unsigned SCLK_DIV_DEF = 4;
   localparam int unsigned FIFO_DEPTH_DEF = 4;

endpackage

// ==== verilog/sop_tick_div.sv ====
// Divider that emits a one-cycle enable pulse every DIV core clocks.
// Assumes the enable is only read on the same clock.

`timescale 1ns/1ps

module sop_tick_div import sop_pkg::*; #(
   parameter int unsigned DIV = SCLK_DIV_DEF
) (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // Enable pulse.
   output logic tick_out
);

   localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic tick;
   } sop_div_st_t;

   sop_div_st_t q, d;

   if (DIV < 1) begin : g_chk
      $error("Divider ratio must be at least one.");
   end

   always_comb begin
      d = q;
      d.tick = (q.cnt == LAST);
      d.cnt = (q.cnt == LAST) ? '0 : q.cnt + CW'(1);
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick_out = q.tick;

endmodule

// ==== verilog/sop_fifo.sv ====
// Small result FIFO with valid and ready on both sides.
// Assumes both sides run on the core clock; read data come from registers.

`timescale 1ns/1ps

module sop_fifo import sop_pkg::*; #(
   parameter int unsigned WIDTH = WORD_W,
   parameter int unsigned DEPTH = FIFO_DEPTH_DEF
) (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // Fill side.
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   // Drain side.
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);

   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
      logic not_full;
   } sop_fifo_st_t;

   sop_fifo_st_t q, d;
   logic push;
   logic pop;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("FIFO depth must be a power of two, at least two.");
   end

   always_comb begin
      d = q;
      push = in_valid_in && q.not_full;
      pop = out_ready_in && (q.count != '0);
      if (push) begin
         d.mem[q.wr] = in_data_in;
         d.wr = q.wr + AW'(1);
      end
      if (pop) begin
         d.rd = q.rd + AW'(1);
      end
      if (push && !pop) begin
         d.count = q.count + (AW+1)'(1);
      end else if (pop && !push) begin
         d.count = q.count - (AW+1)'(1);
      end
      d.not_full = (d.count != FULL);
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         q <= '0;
         q.not_full <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign in_ready_out = q.not_full;
   assign out_valid_out = (q.count != '0);
   assign out_data_out = q.mem[q.rd];

endmodule

// ==== verification/sop_host_model.sv ====
// Host serial port model: runs slave frames and samples master frames.
// Assumes the mode inputs are stable before start_in rises.
`timescale 1ns/1ps
module sop_host_model (
   // Clock and modes.
   input wire logic core_clk_in,
   input wire logic slave_in,
   input wire logic inv_in,
   // Frame control.
   input wire logic start_in,
   input wire logic clr_in,
   input wire logic [31:0] chain_word_in,
   output logic done_out,
   // Link pins.
   input wire logic sdo_in,
   input wire logic mclk_in,
   input wire logic mclk_oe_in,
   output logic sclk_out,
   output logic rsel_n_out,
   output logic chain_out,
   // Captured bits.
   output logic [63:0] rx_out,
   output logic [6:0] cnt_out,
   output logic [7:0] herr_out
);
   // ********
   // Master mode samples on the rise and rechecks the bit on the fall.
   // ********
   logic mclk_q;
   logic [63:0] m_rx;
   logic [63:0] s_rx;
   logic [6:0] m_cnt;
   logic [6:0] s_cnt;
   always @(posedge core_clk_in) begin
      mclk_q <= mclk_in ^ inv_in;
      if (clr_in) begin
         m_rx <= 64'h0;
         m_cnt <= 7'h0;
         herr_out <= 8'h0;
      end else if (!slave_in && mclk_oe_in && (mclk_in ^ inv_in) != mclk_q) begin
         if (!mclk_q) begin
            m_rx <= {m_rx[62:0], sdo_in};
            m_cnt <= m_cnt + 7'h1;
         end else if (sdo_in !== m_rx[0] && m_cnt != 7'h0) begin
            herr_out <= herr_out + 8'h1;
         end
      end
   end
   // ********
   // Slave mode clock idles at the level after the update edge and stands still between frames.
   // ********
   initial begin
      s_rx = 64'h0;
      s_cnt = 7'h0;
      sclk_out = 1'b1;
      rsel_n_out = 1'b1;
      chain_out = 1'b0;
      done_out = 1'b0;
      forever begin
         @(posedge start_in);
         done_out = 1'b0;
         sclk_out = ~inv_in;
         #103.3 rsel_n_out = 1'b0;
         #100;
         for (int k = 0; k < 40; k++) begin
            sclk_out = ~sclk_out;
            s_rx = {s_rx[62:0], sdo_in};
            s_cnt = s_cnt + 7'h1;
            chain_out = chain_word_in[5'(31 - k)];
            #62.5 sclk_out = ~sclk_out;
            #62.5;
         end
         rsel_n_out = 1'b1;
         chain_out = ~chain_out;
         done_out = 1'b1;
      end
   end
   // Each capture process keeps its own record; the mode picks which one shows.
   assign rx_out = slave_in ? s_rx : m_rx;
   assign cnt_out = slave_in ? s_cnt : m_cnt;
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the serial output port.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ps
module tb;
   import sop_pkg::*;
   logic clk, rstn, ser, ext, rdm, inv, ord, busy, vld, start, clr;
   logic [CHAN_W-1:0] a, b;
   logic [31:0] chain, w;
   logic b6, b6oe, b7, b7oe, sdo, mclk, mclk_oe, rdy, act, sclk, rsel_n, chn, done;
   logic [63:0] rx;
   logic [6:0] cnt;
   logic [7:0] herr;
   int err_total, num_checks, seed, n;
   logic [31:0] exp_q[$];

   sop_serial_out #(.CLK_DIV(1), .FIFO_DEPTH(4)) sop_serial_out_inst (
      .core_clk_in(clk), .rstn_in(rstn), .serial_parallel_select_in(ser),
      .clock_source_select_in(ext), .channel_order_select_in(ord),
      .read_select_n_in(rsel_n), .clock_invert_select_in(inv),
      .parallel_bit6_out(b6), .parallel_bit6_oe_out(b6oe),
      .read_mode_or_chain_input_in(ext ? chn : rdm),
      .parallel_bit7_out(b7), .parallel_bit7_oe_out(b7oe), .serial_result_out(sdo),
      .serial_clk_in(sclk), .serial_clk_out(mclk), .serial_clk_oe_out(mclk_oe),
      .result_a_in(a), .result_b_in(b), .result_valid_in(vld),
      .result_ready_out(rdy), .busy_in(busy), .read_active_out(act));
   sop_host_model sop_host_model_inst (
      .core_clk_in(clk), .slave_in(ext), .inv_in(inv), .start_in(start), .clr_in(clr),
      .chain_word_in(chain), .done_out(done), .sdo_in(sdo), .mclk_in(mclk),
      .mclk_oe_in(mclk_oe), .sclk_out(sclk), .rsel_n_out(rsel_n), .chain_out(chn),
      .rx_out(rx), .cnt_out(cnt), .herr_out(herr));

   // ********
   // Checks, stimulus and the closing report.
   // ********
   task automatic chk1(string nm, logic e, logic g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chkw(string nm, logic [63:0] e, logic [63:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic set_mode(logic s, e, r, i, o, bz);
      @(posedge clk);
      ser <= s;
      ext <= e;
      rdm <= r;
      inv <= i;
      ord <= o;
      busy <= bz;
      rstn <= 1'b0;
      clr <= 1'b1;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      clr <= 1'b0;
      exp_q.delete();
      repeat (6) @(posedge clk);
   endtask
   // Called at a rising edge; the caller lowers the valid after the last word.
   task automatic push();
      logic ok;
      a <= 16'($random(seed));
      b <= 16'($random(seed));
      vld <= 1'b1;
      @(negedge clk);
      ok = rdy;
      @(posedge clk);
      if (ok) exp_q.push_back(ord ? {a, b} : {b, a});
   endtask
   task automatic wait_for(ref logic s, input logic v, input int lim);
      n = 0;
      while (s !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk1("wait", v, s);
   endtask
   task automatic mframe(logic bz);
      repeat (30) @(negedge clk);
      chk1("early", 1'b0, act);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      busy <= bz;
      w = exp_q.pop_front();
      wait_for(act, 1'b1, 20);
      chk1("sclk_oe", 1'b1, mclk_oe);
      wait_for(act, 1'b0, 300);
      repeat (3) @(negedge clk);
      chkw("count", 64'h20, 64'(cnt));
      chkw("frame", 64'(w), 64'(rx[31:0]));
      chkw("hold", 64'h0, 64'(herr));
      chk1("clk_idle", inv, mclk);
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000;
      err_total++;
      close_out();
   end
   initial begin
      seed = 32'h03bd;
      err_total = 0;
      num_checks = 0;
      {rstn, ser, ext, rdm, inv, ord, busy, vld, start, clr, a, b, chain} = '0;
      for (int k = 0; k < 2; k++) begin
         set_mode(1'b0, 1'b0, 1'b0, 1'b0, k[0], 1'b0);
         push();
         vld <= 1'b0;
         repeat (8) @(negedge clk);
         w = exp_q[0];
         chk1("bit6", w[22], b6);
         chk1("bit7", w[23], b7);
         chk1("bit8", w[24], sdo);
         chk1("oe", 1'b1, b6oe & b7oe);
         chk1("sclk_oe", 1'b0, mclk_oe);
      end
      for (int m = 0; m < 4; m++) begin
         set_mode(1'b1, 1'b0, 1'b0, m[0], m[1], 1'b1);
         push();
         vld <= 1'b0;
         mframe(1'b0);
      end
      set_mode(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
      push();
      vld <= 1'b0;
      mframe(1'b1);
      for (int i = 0; i < 2; i++) begin
         set_mode(1'b1, 1'b1, 1'b0, i[0], 1'($random(seed)), 1'b0);
         repeat (5) push();
         vld <= 1'b0;
         @(negedge clk);
         chk1("ready", 1'b0, rdy);
         chk1("oe", 1'b0, b6oe | b7oe);
         chk1("sclk_oe", 1'b0, mclk_oe);
         repeat (4) begin
            @(posedge clk);
            clr <= 1'b1;
            start <= 1'b1;
            chain <= $random(seed);
            @(posedge clk);
            clr <= 1'b0;
            start <= 1'b0;
            w = exp_q.pop_front();
            wait_for(done, 1'b1, 700);
            chkw("slave", {24'h0, w, chain[31:24]}, {24'h0, rx[39:0]});
         end
         chk1("drained", 1'b1, rdy);
      end
      close_out();
   end
endmodule
